// File: core/rsc_pkg.sv
// constants and field layout of the reset source combiner and cause register
package rsc_pkg;

   // ****************************************************************
   // bus geometry
   // ****************************************************************
   localparam int          RSC_ADDR_W      = 4;
   localparam int          RSC_DATA_W      = 32;
   localparam int          RSC_REG_W       = 16;
   localparam int          RSC_STRB_W      = RSC_DATA_W / 8;
   localparam int          RSC_LANES       = RSC_REG_W / 8;

   localparam logic [RSC_ADDR_W-1:0] RSC_CAUSE_OFFSET = 4'h0;

   localparam logic [1:0]  RSC_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RSC_RESP_SLVERR = 2'h2;

   // ****************************************************************
   // field positions of reset_cause_control
   // ****************************************************************
   localparam int          RSC_BIT_TRAP    = 15;
   localparam int          RSC_BIT_ILLEGAL = 14;
   localparam int          RSC_BIT_VREG    = 8;
   localparam int          RSC_BIT_EXT     = 7;
   localparam int          RSC_BIT_SOFT    = 6;
   localparam int          RSC_BIT_WDTEN   = 5;
   localparam int          RSC_BIT_WDOG    = 4;
   localparam int          RSC_BIT_SLEEP   = 3;
   localparam int          RSC_BIT_IDLE    = 2;
   localparam int          RSC_BIT_BROWN   = 1;
   localparam int          RSC_BIT_POR     = 0;

   // ****************************************************************
   // masks and reset value
   // ****************************************************************
   localparam logic [RSC_REG_W-1:0] RSC_IMPL_MASK = 16'hc1ff;
   localparam logic [RSC_REG_W-1:0] RSC_POR_VALUE = 16'h0003;
   localparam logic [RSC_REG_W-1:0] RSC_WDOG_MASK = 16'h0010;

endpackage

// File: core/rsc_top.sv
// reset source combiner with the reset cause and control register on AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
module rsc_top
   import rsc_pkg::*;
(
   input  wire logic                            i_core_clk,          // 10 MHz core clock
   input  wire logic                            i_reset_n,           // async power-on reset
   // reset sources
   input  wire logic                            i_power_on,          // power-on monitor active
   input  wire logic                            i_brownout,          // brown-out monitor active
   input  wire logic                            i_master_clear_pin,  // pin reset request
   input  wire logic                            i_reset_instr,       // reset instruction
   input  wire logic                            i_watchdog_timeout,  // watchdog expired
   input  wire logic                            i_trap_conflict,     // trap conflict
   input  wire logic                            i_illegal_op,        // illegal op or bad pointer
   // power saving and configuration
   input  wire logic                            i_power_save_sleep,  // sleep instruction pulse
   input  wire logic                            i_power_save_idle,   // idle instruction pulse
   input  wire logic                            i_cfg_watchdog_force,// fuse forces watchdog on
   // block outputs
   output logic                                 o_system_reset_out,  // combined reset, high
   output logic                                 o_watchdog_enable,   // watchdog run enable
   output logic                                 o_regulator_sleep_standby, // standby in sleep
   // AXI4-Lite slave
   input  wire logic [rsc_pkg::RSC_ADDR_W-1:0]  i_axi_awaddr,        // write address
   input  wire logic                            i_axi_awvalid,       // write address valid
   output logic                                 o_axi_awready,       // write address ready
   input  wire logic [rsc_pkg::RSC_DATA_W-1:0]  i_axi_wdata,         // write data
   input  wire logic [rsc_pkg::RSC_STRB_W-1:0]  i_axi_wstrb,         // byte enables
   input  wire logic                            i_axi_wvalid,        // write data valid
   output logic                                 o_axi_wready,        // write data ready
   output logic [1:0]                           o_axi_bresp,         // write response
   output logic                                 o_axi_bvalid,        // write response valid
   input  wire logic                            i_axi_bready,        // write response ready
   input  wire logic [rsc_pkg::RSC_ADDR_W-1:0]  i_axi_araddr,        // read address
   input  wire logic                            i_axi_arvalid,       // read address valid
   output logic                                 o_axi_arready,       // read address ready
   output logic [rsc_pkg::RSC_DATA_W-1:0]       o_axi_rdata,         // read data
   output logic [1:0]                           o_axi_rresp,         // read response
   output logic                                 o_axi_rvalid,        // read data valid
   input  wire logic                            i_axi_rready         // read data ready
);
   import rsc_pkg::*;

   // ****************************************************************
   // reset combining
   // ****************************************************************
   logic                   any_source;
   logic                   hold_reg;

   assign any_source = i_power_on | i_brownout | i_master_clear_pin | i_reset_instr
                     | i_watchdog_timeout | i_trap_conflict | i_illegal_op;

   // asserting is immediate, release waits for a clock edge so that every
   // consumer of the reset leaves it in the same cycle
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         hold_reg <= 1'b1;
      else
         hold_reg <= any_source;
   end

   assign o_system_reset_out = any_source | hold_reg;

   // ****************************************************************
   // write channel
   // ****************************************************************
   logic                   aw_hold_reg;
   logic [RSC_ADDR_W-1:0]  aw_addr_reg;
   logic                   w_hold_reg;
   logic [RSC_DATA_W-1:0]  w_data_reg;
   logic [RSC_STRB_W-1:0]  w_strb_reg;
   logic                   bvalid_reg;
   logic [1:0]             bresp_reg;
   logic                   aw_fire;
   logic                   w_fire;
   logic                   wr_go;
   logic                   wr_hit;

   assign o_axi_awready = !aw_hold_reg && !bvalid_reg;
   assign o_axi_wready  = !w_hold_reg && !bvalid_reg;
   assign aw_fire       = i_axi_awvalid && o_axi_awready;
   assign w_fire        = i_axi_wvalid && o_axi_wready;
   assign wr_go         = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_hit        = wr_go && (aw_addr_reg == RSC_CAUSE_OFFSET);

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
      end
      else if (aw_fire)
      begin
         aw_hold_reg <= 1'b1;
         aw_addr_reg <= i_axi_awaddr;
      end
      else if (wr_go)
         aw_hold_reg <= 1'b0;
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         w_hold_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end
      else if (w_fire)
      begin
         w_hold_reg <= 1'b1;
         w_data_reg <= i_axi_wdata;
         w_strb_reg <= i_axi_wstrb;
      end
      else if (wr_go)
         w_hold_reg <= 1'b0;
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RSC_RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_hit ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
      end
      else if (i_axi_bready)
         bvalid_reg <= 1'b0;
   end

   assign o_axi_bvalid = bvalid_reg;
   assign o_axi_bresp  = bresp_reg;

   // ****************************************************************
   // reset cause register
   // ****************************************************************
   logic [RSC_REG_W-1:0]   cause_reg;
   logic [RSC_REG_W-1:0]   cause_next;
   logic [RSC_REG_W-1:0]   sw_value;
   logic [RSC_REG_W-1:0]   after_clear;
   logic [RSC_REG_W-1:0]   hw_set;
   logic                   power_save_instruction;

   // byte lanes that software touches replace the stored bits
   for (genvar g = 0; g < RSC_LANES; g++)
   begin : g_lane
      assign sw_value[g*8 +: 8] = (wr_hit && w_strb_reg[g]) ? w_data_reg[g*8 +: 8]
                                                             : cause_reg[g*8 +: 8];
   end

   assign power_save_instruction = i_power_save_sleep | i_power_save_idle;
   assign after_clear = sw_value & ~(power_save_instruction ? RSC_WDOG_MASK
                                                            : 16'h0000);

   always_comb
   begin
      hw_set                  = '0;
      hw_set[RSC_BIT_TRAP]    = i_trap_conflict;
      hw_set[RSC_BIT_ILLEGAL] = i_illegal_op;
      hw_set[RSC_BIT_EXT]     = i_master_clear_pin;
      hw_set[RSC_BIT_SOFT]    = i_reset_instr;
      hw_set[RSC_BIT_WDOG]    = i_watchdog_timeout;
      hw_set[RSC_BIT_SLEEP]   = i_power_save_sleep;
      hw_set[RSC_BIT_IDLE]    = i_power_save_idle;
      hw_set[RSC_BIT_BROWN]   = i_brownout;
   end

   // hardware sets beat any clear in the same cycle; power-on beats all
   assign cause_next = i_power_on ? RSC_POR_VALUE
                                  : ((after_clear | hw_set) & RSC_IMPL_MASK);

   // only the power-on reset reinitialises the register, the other resets
   // leave it alone so software can read their cause afterwards
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         cause_reg <= RSC_POR_VALUE;
      else
         cause_reg <= cause_next;
   end

   assign o_watchdog_enable         = i_cfg_watchdog_force | cause_reg[RSC_BIT_WDTEN];
   assign o_regulator_sleep_standby = cause_reg[RSC_BIT_VREG];

   // ****************************************************************
   // read channel
   // ****************************************************************
   logic                   rvalid_reg;
   logic [RSC_DATA_W-1:0]  rdata_reg;
   logic [1:0]             rresp_reg;
   logic                   ar_fire;
   logic                   rd_hit;

   assign o_axi_arready = !rvalid_reg;
   assign ar_fire       = i_axi_arvalid && o_axi_arready;
   // the word is captured at the address handshake and held until rready, never torn
   assign rd_hit        = (i_axi_araddr == RSC_CAUSE_OFFSET);

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= RSC_RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_hit ? {16'h0000, cause_reg & RSC_IMPL_MASK} : '0;
         rresp_reg  <= rd_hit ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
      end
      else if (i_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign o_axi_rvalid = rvalid_reg;
   assign o_axi_rdata  = rdata_reg;
   assign o_axi_rresp  = rresp_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_reset_any;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      any_source |-> o_system_reset_out;
   endproperty
   a_reset_any: assert property (p_reset_any)
      else $error("system reset low while a source is active");

   property p_reset_release;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      $fell(any_source) |-> o_system_reset_out ##1 (any_source || !o_system_reset_out);
   endproperty
   a_reset_release: assert property (p_reset_release)
      else $error("system reset not released one edge after sources end");

   property p_power_on_clears;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_power_on |=> (cause_reg == RSC_POR_VALUE);
   endproperty
   a_power_on_clears: assert property (p_power_on_clears)
      else $error("power-on did not leave only the power-on flags");

   property p_trap_flag;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_trap_conflict && !i_power_on) |=> cause_reg[RSC_BIT_TRAP];
   endproperty
   a_trap_flag: assert property (p_trap_flag)
      else $error("trap conflict flag not set");

   property p_illegal_flag;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_illegal_op && !i_power_on) |=> cause_reg[RSC_BIT_ILLEGAL];
   endproperty
   a_illegal_flag: assert property (p_illegal_flag)
      else $error("illegal op flag not set");

   property p_unimpl_zero;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      o_axi_rvalid |-> (o_axi_rdata[13:9] == 5'h00) && (o_axi_rdata[31:16] == 16'h0000);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero)
      else $error("unimplemented bits read nonzero");

   property p_pin_flag;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_master_clear_pin && !i_power_on) |=> cause_reg[RSC_BIT_EXT];
   endproperty
   a_pin_flag: assert property (p_pin_flag)
      else $error("pin reset flag not set");

   property p_soft_flag;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_reset_instr && !i_power_on) |=> cause_reg[RSC_BIT_SOFT];
   endproperty
   a_soft_flag: assert property (p_soft_flag)
      else $error("software reset flag not set");

   property p_wdog_flag;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (i_watchdog_timeout && !i_power_on) |=> cause_reg[RSC_BIT_WDOG];
   endproperty
   a_wdog_flag: assert property (p_wdog_flag)
      else $error("watchdog flag not set");

   property p_wdog_clear;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (power_save_instruction && !i_watchdog_timeout) |=> !cause_reg[RSC_BIT_WDOG];
   endproperty
   a_wdog_clear: assert property (p_wdog_clear)
      else $error("watchdog flag survived a power-save instruction");

   property p_sleep_idle;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      ((i_power_save_sleep || i_power_save_idle) && !i_power_on)
         |=> (cause_reg[RSC_BIT_SLEEP] || !$past(i_power_save_sleep))
          && (cause_reg[RSC_BIT_IDLE] || !$past(i_power_save_idle));
   endproperty
   a_sleep_idle: assert property (p_sleep_idle)
      else $error("sleep or idle flag not set");

   property p_brown_flag;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      i_brownout |=> cause_reg[RSC_BIT_BROWN];
   endproperty
   a_brown_flag: assert property (p_brown_flag)
      else $error("brown-out flag not set");

   property p_soft_write;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (wr_hit && (w_strb_reg[1:0] == 2'h3) && !any_source && !power_save_instruction
         && !o_system_reset_out)
         |=> (cause_reg == (w_data_reg[15:0] & RSC_IMPL_MASK)) && !o_system_reset_out;
   endproperty
   a_soft_write: assert property (p_soft_write)
      else $error("software write not stored or caused a reset");

   property p_wdt_enable;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (wr_hit && w_strb_reg[0] && !w_data_reg[5] && !i_cfg_watchdog_force)
         ##1 !i_cfg_watchdog_force |-> !o_watchdog_enable;
   endproperty
   a_wdt_enable: assert property (p_wdt_enable)
      else $error("watchdog still enabled after software disable");

   property p_regulator;
      @(posedge i_core_clk) disable iff (!i_reset_n)
      (wr_hit && w_strb_reg[1] && !i_power_on)
         |=> o_regulator_sleep_standby == $past(w_data_reg[RSC_BIT_VREG]);
   endproperty
   a_regulator: assert property (p_regulator)
      else $error("regulator standby bit not written");

endmodule

// File: verif/rsc_src_model.sv
// model of the on-chip reset sources: pin, supply monitors, watchdog and cpu traps
module rsc_src_model #(
   parameter int HOLD = 3                    // cycles a fired source stays active
)
(
   input  wire logic       i_core_clk,       // core clock
   input  wire logic       i_reset_n,        // async reset, low
   input  wire logic [6:0] i_fire,           // one-hot request from the bench
   output logic      [6:0] o_src             // por,bor,pin,instr,wdt,trap,illegal
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [6:0] mask_reg;
   logic [3:0] cnt_reg;

   // a real source is a level that lasts several cycles, not a one-cycle blip
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         mask_reg <= 7'h00;
         cnt_reg  <= 4'h0;
      end
      else if (i_fire != 7'h00)
      begin
         mask_reg <= i_fire;
         cnt_reg  <= 4'(HOLD);
      end
      else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
   end

   assign o_src = (cnt_reg != 4'h0) ? mask_reg : 7'h00;
endmodule

// File: verif/rsc_top_tb.sv
// self-checking bench for the reset source combiner and its cause register
module rsc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rsc_pkg::*;

   logic        clk = 1'b0, reset_n = 1'b0, sleep = 1'b0, idle = 1'b0, force_wdt = 1'b0;
   logic [6:0]  fire = 7'h00, src;
   logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h3;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, sys_rst, wdt_en, vreg;
   logic [1:0]  bresp, rresp;
   int          n_errors = 0, checked = 0;

   always #50 clk = ~clk;

   rsc_src_model #(.HOLD(3)) model_u (.i_core_clk(clk), .i_reset_n(reset_n), .i_fire(fire),
      .o_src(src));

   rsc_top dut_u (.i_core_clk(clk), .i_reset_n(reset_n), .i_power_on(src[0]),
      .i_brownout(src[1]), .i_master_clear_pin(src[2]), .i_reset_instr(src[3]),
      .i_watchdog_timeout(src[4]), .i_trap_conflict(src[5]), .i_illegal_op(src[6]),
      .i_power_save_sleep(sleep), .i_power_save_idle(idle), .i_cfg_watchdog_force(force_wdt),
      .o_system_reset_out(sys_rst), .o_watchdog_enable(wdt_en),
      .o_regulator_sleep_standby(vreg), .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
      .o_axi_awready(awready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
      .i_axi_wvalid(wvalid), .o_axi_wready(wready), .o_axi_bresp(bresp),
      .o_axi_bvalid(bvalid), .i_axi_bready(bready), .i_axi_araddr(araddr),
      .i_axi_arvalid(arvalid), .o_axi_arready(arready), .o_axi_rdata(rdata),
      .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize();
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ****************************************************************
   // axi4-lite master: entered and left just after a rising edge
   // ****************************************************************
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (!(bvalid && bready) && n < 50);
      r = bresp;
      bready <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0, "write response timeout");
      // let an edge pass so a following call never reassigns bready in this step
      @(posedge clk);
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (!(rvalid && rready) && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0, "read response timeout");
      // let an edge pass so a following call never reassigns rready in this step
      @(posedge clk);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_por_value();
      logic [31:0] d;
      logic [1:0]  r;
      @(negedge clk);
      chk({31'h0, sys_rst}, 32'h0, "reset out after release");
      chk({30'h0, vreg, wdt_en}, 32'h0, "controls off after power-on");
      @(posedge clk);
      axi_rd(RSC_CAUSE_OFFSET, d, r);
      chk(d, 32'h0000_0003, "power-on value");
      chk({30'h0, r}, 32'h0, "read resp okay");
   endtask

   task automatic t_sources();
      int          bitpos [7] = '{0, 1, 7, 6, 4, 15, 14};
      logic [31:0] d, exp;
      logic [1:0]  r;
      int          n;
      for (int i = 0; i < 7; i++)
      begin
         // clear flags after reading so each cause stands alone; power-on starts from
         // all ones, the others keep the standby bit to show the stored bits survive
         axi_wr(RSC_CAUSE_OFFSET, (i == 0) ? 32'h0000_c1ff : 32'h0000_0100, r);
         fire <= 7'(1 << i);
         @(posedge clk);
         fire <= 7'h00;
         @(negedge clk);
         chk({31'h0, sys_rst}, 32'h1, "reset out while source active");
         n = 0;
         while (src != 7'h00 && n < 20)
         begin
            @(negedge clk);
            n++;
         end
         chk({31'h0, sys_rst}, 32'h1, "reset out one cycle after source");
         @(negedge clk);
         chk({31'h0, sys_rst}, 32'h0, "reset out released");
         @(posedge clk);
         axi_rd(RSC_CAUSE_OFFSET, d, r);
         exp = (i == 0) ? 32'h0000_0003 : (32'h0000_0100 | (32'h1 << bitpos[i]));
         chk(d, exp, "cause flag");
      end
   endtask

   task automatic t_sw_write();
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(RSC_CAUSE_OFFSET, 32'hffff_ffff, r);
      chk({30'h0, r}, {30'h0, RSC_RESP_OKAY}, "write resp okay");
      @(negedge clk);
      chk({31'h0, sys_rst}, 32'h0, "software set no reset");
      chk({30'h0, vreg, wdt_en}, 32'h3, "standby and watchdog on");
      @(posedge clk);
      axi_rd(RSC_CAUSE_OFFSET, d, r);
      chk(d, 32'h0000_c1ff, "all writable bits");
      axi_wr(RSC_CAUSE_OFFSET, 32'h0, r);
      @(negedge clk);
      chk({30'h0, vreg, wdt_en}, 32'h0, "standby and watchdog off");
      @(posedge clk);
      force_wdt <= 1'b1;
      @(negedge clk);
      chk({31'h0, wdt_en}, 32'h1, "fuse forces watchdog");
      @(posedge clk);
      force_wdt <= 1'b0;
      // only the upper byte lane is enabled, the lower lane must keep its zeros
      wstrb <= 4'h2;
      axi_wr(RSC_CAUSE_OFFSET, 32'h0000_ffff, r);
      wstrb <= 4'h3;
      @(negedge clk);
      chk({30'h0, vreg, wdt_en}, 32'h2, "lane write, fuse released");
      @(posedge clk);
      axi_rd(RSC_CAUSE_OFFSET, d, r);
      chk(d, 32'h0000_c100, "upper lane only");
   endtask

   task automatic t_power_save();
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(RSC_CAUSE_OFFSET, 32'h0000_0010, r);
      sleep <= 1'b1;
      @(posedge clk);
      sleep <= 1'b0;
      axi_rd(RSC_CAUSE_OFFSET, d, r);
      chk(d, 32'h0000_0008, "sleep sets flag, clears timeout");
      axi_wr(RSC_CAUSE_OFFSET, 32'h0, r);
      idle <= 1'b1;
      @(posedge clk);
      idle <= 1'b0;
      axi_rd(RSC_CAUSE_OFFSET, d, r);
      chk(d, 32'h0000_0004, "idle flag");
   endtask

   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(4'h8, 32'h0000_ffff, r);
      chk({30'h0, r}, {30'h0, RSC_RESP_SLVERR}, "unmapped write resp");
      axi_rd(4'h4, d, r);
      chk({30'h0, r}, {30'h0, RSC_RESP_SLVERR}, "unmapped read resp");
      chk(d, 32'h0, "unmapped read data");
      axi_rd(RSC_CAUSE_OFFSET, d, r);
      chk(d, 32'h0000_0004, "register kept after unmapped write");
   endtask

   initial
   begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_por_value();
      t_sources();
      t_sw_write();
      t_power_save();
      t_unmapped();
      summarize();
   end

   // the whole run needs well under a thousand cycles
   initial
   begin
      #500000;
      n_errors++;
      summarize();
   end
endmodule
